// file: include/pm_event_map.svh
// Register offsets, field positions, reset values and timing counts of the event logic
`ifndef PM_EVENT_MAP_SVH
`define PM_EVENT_MAP_SVH

`define PM_CTRL_OFS     8'h00
`define PM_STAT_OFS     8'h04
`define PM_MASK_OFS     8'h08
`define PM_PINS_OFS     8'h0c

`define CTL_EXT_EN      0
`define CTL_LID_EN      1
`define CTL_PWR_EN      2
`define CTL_RING_EN     3
`define CTL_ALERT_EN    4
`define CTL_LID_GPI     5
`define CTL_RING_GPI    6
`define CTL_ALERT_GPI   7
`define CTL_HALT_GPO    8
`define CTL_HALT_REQ    9
`define CTL_GPO_VAL     10
`define CTL_ROUTE_LO    11
`define CTL_W           13
`define CTL_RST         13'h0400

`define ST_EXT          0
`define ST_LID          1
`define ST_PWR          2
`define ST_RING         3
`define ST_ALERT        4
`define ST_BUSACT       5
`define ST_W            6
`define ST_RST          6'h00
`define MASK_RST        6'h00

`define PIN_LID         0
`define PIN_PWR         1
`define PIN_RING        2
`define PIN_ALERT       3
`define PIN_EXT         4
`define PIN_REQ_LO      5
`define PIN_HALT        9

`define SY_EXT          0
`define SY_LID          1
`define SY_PWR          2
`define SY_RING         3
`define SY_ALERT        4
`define SY_REQ_LO       5
`define SY_W            9
`define SY_RST          9'h1ff

`define DEBOUNCE_MS     16
`define CLK_KHZ         200000
`define DEBOUNCE_CYC    (`DEBOUNCE_MS * `CLK_KHZ)

`endif

// file: include/pm_event_pkg.sv
// Types shared by the power-management event logic
`default_nettype none
package pm_event_pkg;
	typedef enum logic [1:0] {
		ROUTE_IRQ,
		ROUTE_SMI,
		ROUTE_RESUME,
		ROUTE_NONE
	} alert_route_t;

	typedef enum logic {
		BUS_IDLE,
		BUS_DATA
	} bus_state_t;
endpackage
`default_nettype wire

// file: logic/pm_debounce.sv
// Level debouncer: output follows the input once it has held steady for a full interval
`timescale 1ns/1ps
`default_nettype none
module pm_debounce #(
	parameter int unsigned DB_CYCLES = 3200000,
	parameter int unsigned CNT_W     = 22
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic din,
	output logic      dout_ff
);
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] last_cnt;

	assign last_cnt = CNT_W'(DB_CYCLES - 1);

	// Any bounce back to the held level restarts the interval
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff <= '0;
		end else if (din == dout_ff) begin
			cnt_ff <= '0;
		end else if (cnt_ff == last_cnt) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dout_ff <= 1'b1;
		end else if (din != dout_ff && cnt_ff == last_cnt) begin
			dout_ff <= din;
		end
	end
endmodule // pm_debounce
`default_nettype wire

// file: logic/pm_event_input.sv
// Power-management event inputs, clock-halt pin and their register interface
`timescale 1ns/1ps
`default_nettype none
`include "pm_event_map.svh"

// Overview of operation
// R1: Enabled falling edge on input raises management interrupt
// R2: One-cycle assertion of external input is caught
// R3: Source keeps input released four cycles
// R4: Pull external pin low on serial interrupt request
// R5: Lid edges of both directions raise interrupt
// R6: Lid and power button debounced sixteen milliseconds
// R7: Lid pin readable as general input
// R8: Sample four bus request monitor inputs
// R9: Drive clock-halt low to stop bus clocks
// R10: Own bus clock keeps running while halted
// R11: Clock-halt pin usable as general output
// R12: Ring input wakes, or serves as input
// R13: Resume reset clears all suspend-well logic
// R14: Bus alert raises irq, interrupt or resume
// R15: Management bus pins never driven
// R16: Asynchronous inputs synchronized before any use
module pm_event_input
	import pm_event_pkg::*;
#(
	parameter int unsigned DB_CYCLES = `DEBOUNCE_CYC,
	parameter int unsigned REQ_W     = 4
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic                  hreadyout,
	output logic                  hresp,
	output logic [31:0]           hrdata,
	input  wire logic             ext_mgmt_irq_n_in,
	output logic                  ext_mgmt_irq_n_out,
	output logic                  ext_mgmt_irq_n_oe,
	input  wire logic             serirq_smi_req,
	input  wire logic             lid_in,
	input  wire logic             power_button_n,
	input  wire logic             ring_wake_n,
	input  wire logic             mgmt_bus_alert_n,
	input  wire logic [REQ_W-1:0] bus_req_monitor_n,
	output logic                  bus_clk_halt_n,
	output logic                  smb_clk_out,
	output logic                  smb_clk_oe,
	output logic                  smb_data_out,
	output logic                  smb_data_oe,
	output logic                  sys_mgmt_irq_n,
	output logic                  alert_irq,
	output logic                  pm_resume,
	output logic                  irq
);
	localparam int unsigned SY_N = 5 + REQ_W;
	localparam int unsigned CNT_W = $clog2(DB_CYCLES + 1);

	logic [SY_N-1:0]      sync1_ff;
	logic [SY_N-1:0]      sync2_ff;
	logic [SY_N-1:0]      sync3_ff;
	logic [SY_N-1:0]      stable_ff;
	logic                 lid_db;
	logic                 pwr_db;
	logic                 lid_db_d_ff;
	logic                 pwr_db_d_ff;
	logic                 ring_d_ff;
	logic                 alert_d_ff;
	logic [`CTL_W-1:0]    ctrl_ff;
	logic [`ST_W-1:0]     stat_ff;
	logic [`ST_W-1:0]     nxt_stat;
	logic [`ST_W-1:0]     stat_set;
	logic [`ST_W-1:0]     stat_clr;
	logic [`ST_W-1:0]     mask_ff;
	bus_state_t           bus_ff;
	logic [7:0]           addr_ff;
	logic                 wr_ff;
	logic                 hreadyout_ff;
	logic [31:0]          hrdata_ff;
	logic                 ext_oe_ff;
	logic                 halt_n_ff;
	logic                 smi_n_ff;
	logic                 alert_irq_ff;
	logic                 resume_ff;
	logic                 irq_ff;
	logic                 smb_oe_ff;
	logic                 take;
	logic                 wr_now;
	logic                 ext_fall;
	logic                 lid_edge;
	logic                 pwr_press;
	logic                 ring_fall;
	logic                 alert_fall;
	alert_route_t         route;
	logic [SY_N-1:0]      pins_raw;

	// Same-clock register field read
	function automatic logic ctl(input logic [`CTL_W-1:0] c, input int unsigned pos);
		ctl = c[pos];
	endfunction

	// Register read multiplexer, unmapped offsets read zero
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			`PM_CTRL_OFS: v[`CTL_W-1:0] = ctrl_ff;
			`PM_STAT_OFS: v[`ST_W-1:0] = stat_ff;
			`PM_MASK_OFS: v[`ST_W-1:0] = mask_ff;
			`PM_PINS_OFS: begin
				v[`PIN_LID]   = lid_db;
				v[`PIN_PWR]   = pwr_db;
				v[`PIN_RING]  = stable_ff[`SY_RING];
				v[`PIN_ALERT] = stable_ff[`SY_ALERT];
				v[`PIN_EXT]   = stable_ff[`SY_EXT];
				v[`PIN_REQ_LO +: REQ_W] = stable_ff[`SY_REQ_LO +: REQ_W];
				v[`PIN_HALT]  = halt_n_ff;
			end
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	assign pins_raw = {bus_req_monitor_n, mgmt_bus_alert_n, ring_wake_n, power_button_n,
		lid_in, ext_mgmt_irq_n_in};

	// Three-stage capture of every pin; a change is taken once stages two and three agree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_ff  <= SY_N'(`SY_RST);
			sync2_ff  <= SY_N'(`SY_RST);
			sync3_ff  <= SY_N'(`SY_RST);
			stable_ff <= SY_N'(`SY_RST);
		end else begin
			sync1_ff  <= pins_raw; // R16 R2
			sync2_ff  <= sync1_ff;
			sync3_ff  <= sync2_ff;
			for (int i = 0; i < SY_N; i++) begin
				if (sync2_ff[i] == sync3_ff[i]) begin
					stable_ff[i] <= sync3_ff[i]; // R16
				end
			end
		end
	end

	pm_debounce #(
		.DB_CYCLES (DB_CYCLES),
		.CNT_W     (CNT_W)
	) u_lid_db (
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     (stable_ff[`SY_LID]),
		.dout_ff (lid_db)
	); // R6

	pm_debounce #(
		.DB_CYCLES (DB_CYCLES),
		.CNT_W     (CNT_W)
	) u_pwr_db (
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     (stable_ff[`SY_PWR]),
		.dout_ff (pwr_db)
	); // R6

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lid_db_d_ff <= 1'b1;
			pwr_db_d_ff <= 1'b1;
			ring_d_ff   <= 1'b1;
			alert_d_ff  <= 1'b1;
		end else begin
			lid_db_d_ff <= lid_db;
			pwr_db_d_ff <= pwr_db;
			ring_d_ff   <= stable_ff[`SY_RING];
			alert_d_ff  <= stable_ff[`SY_ALERT];
		end
	end

	assign route = alert_route_t'(ctrl_ff[`CTL_ROUTE_LO +: 2]);

	// Falls are taken between stages two and three so a one-cycle pulse counts; our own
	// drive of the shared line must not read back as a new request
	assign ext_fall   = sync3_ff[`SY_EXT] && !sync2_ff[`SY_EXT] && !ext_oe_ff; // R1 R2 R3
	assign lid_edge   = lid_db_d_ff != lid_db; // R5
	assign pwr_press  = pwr_db_d_ff && !pwr_db;
	assign ring_fall  = ring_d_ff && !stable_ff[`SY_RING];
	assign alert_fall = alert_d_ff && !stable_ff[`SY_ALERT];

	always_comb begin
		stat_set = '0;
		stat_set[`ST_EXT]    = ext_fall && ctl(ctrl_ff, `CTL_EXT_EN); // R1
		stat_set[`ST_LID]    = lid_edge && ctl(ctrl_ff, `CTL_LID_EN)
			&& !ctl(ctrl_ff, `CTL_LID_GPI); // R5 R7
		stat_set[`ST_PWR]    = pwr_press && ctl(ctrl_ff, `CTL_PWR_EN);
		stat_set[`ST_RING]   = ring_fall && ctl(ctrl_ff, `CTL_RING_EN)
			&& !ctl(ctrl_ff, `CTL_RING_GPI); // R12
		stat_set[`ST_ALERT]  = alert_fall && ctl(ctrl_ff, `CTL_ALERT_EN)
			&& !ctl(ctrl_ff, `CTL_ALERT_GPI); // R14
		stat_set[`ST_BUSACT] = !(&stable_ff[`SY_REQ_LO +: REQ_W]); // R8
	end

	assign take   = hsel && hready && htrans[1];
	assign wr_now = (bus_ff == BUS_DATA) && wr_ff && !hreadyout_ff;

	always_comb begin
		stat_clr = '0;
		if (wr_now && addr_ff == `PM_STAT_OFS) begin
			stat_clr = hwdata[`ST_W-1:0];
		end
		// A new event in the clearing cycle survives
		nxt_stat = (stat_ff & ~stat_clr) | stat_set;
	end

	// Bus slave: one wait state, then write lands and read data stands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_ff       <= BUS_IDLE;
			addr_ff      <= 8'h00;
			wr_ff        <= 1'b0;
			hreadyout_ff <= 1'b1;
		end else begin
			unique case (bus_ff)
				BUS_IDLE: begin
					if (take) begin
						bus_ff       <= BUS_DATA;
						addr_ff      <= {haddr[7:2], 2'b00};
						wr_ff        <= hwrite;
						hreadyout_ff <= 1'b0;
					end
				end
				BUS_DATA: begin
					if (!hreadyout_ff) begin
						hreadyout_ff <= 1'b1;
					end else if (take) begin
						addr_ff      <= {haddr[7:2], 2'b00};
						wr_ff        <= hwrite;
						hreadyout_ff <= 1'b0;
					end else begin
						bus_ff <= BUS_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (bus_ff == BUS_DATA && !hreadyout_ff && !wr_ff) begin
			hrdata_ff <= rd_mux(addr_ff);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= `CTL_RST; // R13
			mask_ff <= `MASK_RST;
		end else if (wr_now) begin
			if (addr_ff == `PM_CTRL_OFS) begin
				ctrl_ff <= hwdata[`CTL_W-1:0];
			end
			if (addr_ff == `PM_MASK_OFS) begin
				mask_ff <= hwdata[`ST_W-1:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_ff <= `ST_RST; // R13
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	// Output pins and request lines, all registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_oe_ff    <= 1'b0;
			halt_n_ff    <= 1'b1;
			smi_n_ff     <= 1'b1;
			alert_irq_ff <= 1'b0;
			resume_ff    <= 1'b0;
			irq_ff       <= 1'b0;
			smb_oe_ff    <= 1'b0;
		end else begin
			ext_oe_ff <= serirq_smi_req; // R4
			// Halting only the bus clock outputs; hclk itself stays free-running
			if (ctl(ctrl_ff, `CTL_HALT_GPO)) begin
				halt_n_ff <= ctl(ctrl_ff, `CTL_GPO_VAL); // R11
			end else begin
				halt_n_ff <= !ctl(ctrl_ff, `CTL_HALT_REQ); // R9 R10
			end
			smi_n_ff <= !(stat_ff[`ST_EXT] || stat_ff[`ST_LID]
				|| (stat_ff[`ST_ALERT] && route == ROUTE_SMI)); // R1 R5 R14
			alert_irq_ff <= stat_ff[`ST_ALERT] && route == ROUTE_IRQ; // R14
			resume_ff    <= stat_ff[`ST_RING] || stat_ff[`ST_PWR]
				|| (stat_ff[`ST_ALERT] && route == ROUTE_RESUME); // R12 R14
			irq_ff    <= |(stat_ff & mask_ff);
			smb_oe_ff <= 1'b0; // R15
		end
	end

	assign hreadyout          = hreadyout_ff;
	assign hresp              = 1'b0;
	assign hrdata             = hrdata_ff;
	assign ext_mgmt_irq_n_out = 1'b0;
	assign ext_mgmt_irq_n_oe  = ext_oe_ff;
	assign bus_clk_halt_n     = halt_n_ff;
	assign smb_clk_out        = 1'b0;
	assign smb_clk_oe         = smb_oe_ff;
	assign smb_data_out       = 1'b0;
	assign smb_data_oe        = smb_oe_ff;
	assign sys_mgmt_irq_n     = smi_n_ff;
	assign alert_irq          = alert_irq_ff;
	assign pm_resume          = resume_ff;
	assign irq                = irq_ff;

	logic unused_ok;
	assign unused_ok = ^{haddr[31:8], haddr[1:0], hsize, hwdata[31:`CTL_W]};
endmodule // pm_event_input
`default_nettype wire

// file: sim/pm_event_input_checker.sv
// Port-level assertions for the power-management event logic
`timescale 1ns/1ps
`default_nettype none
module pm_event_input_checker (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       serirq_smi_req,
	input wire logic       ext_mgmt_irq_n_out,
	input wire logic       ext_mgmt_irq_n_oe,
	input wire logic       smb_clk_oe,
	input wire logic       smb_data_oe,
	input wire logic       sys_mgmt_irq_n,
	input wire logic       alert_irq,
	input wire logic       bus_clk_halt_n
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	bus_okay_a: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	wait_state_a: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
		else $error("transfer not one wait state");
	smb_idle_a: assert property (!smb_clk_oe && !smb_data_oe)
		else $error("management bus pin driven");
	pull_low_a: assert property ($rose(serirq_smi_req) |=> ext_mgmt_irq_n_oe)
		else $error("request line not pulled");
	pull_release_a: assert property ($fell(serirq_smi_req) |=> !ext_mgmt_irq_n_oe)
		else $error("request line not released");
	drive_zero_a: assert property (ext_mgmt_irq_n_oe |-> !ext_mgmt_irq_n_out)
		else $error("request line driven high");
	// Status is sticky, so the interrupt only lifts after a register write
	smi_sticky_a: assert property ($rose(sys_mgmt_irq_n) |->
		!$past(hreadyout) || !$past(hreadyout, 2))
		else $error("interrupt lifted without write");
	halt_by_write_a: assert property ($changed(bus_clk_halt_n) |->
		!$past(hreadyout) || !$past(hreadyout, 2))
		else $error("clock halt moved without write");

	cover property ($fell(sys_mgmt_irq_n));
	cover property ($rose(alert_irq));
	cover property ($fell(bus_clk_halt_n));
endmodule // pm_event_input_checker

bind pm_event_input pm_event_input_checker chk (.hclk, .hresetn, .hsel, .htrans, .hready,
	.hreadyout, .hresp, .serirq_smi_req, .ext_mgmt_irq_n_out, .ext_mgmt_irq_n_oe, .smb_clk_oe,
	.smb_data_oe, .sys_mgmt_irq_n, .alert_irq, .bus_clk_halt_n);
`default_nettype wire

// file: sim/pm_event_sources.sv
// Behavioural event sources: lid, buttons, alert and the open-drain request line
`timescale 1ns/1ps
`default_nettype none
module pm_event_sources (
	input  wire logic hclk,
	input  wire logic oe,
	output logic      ext_pin,
	output logic      lid,
	output logic      pwr_n,
	output logic      ring_n,
	output logic      alert_n
);
	logic [4:0] lv_ff = 5'h1f;

	// Pulled up unless either party sinks the line
	assign ext_pin = !oe && lv_ff[0];
	assign lid     = lv_ff[1];
	assign pwr_n   = lv_ff[2];
	assign ring_n  = lv_ff[3];
	assign alert_n = lv_ff[4];

	// Callers hold a request low one cycle and released at least four
	task drive(input int idx, input logic v, input int n);
		@(posedge hclk);
		lv_ff[idx] <= v;
		repeat (n) @(posedge hclk);
	endtask
endmodule // pm_event_sources
`default_nettype wire

// file: sim/pm_event_input_tb_top.sv
// Self-checking bench for the power-management event logic
`timescale 1ns/1ps
`default_nettype none
module pm_event_input_tb_top;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_dp, serirq_smi_req;
	logic        ext_mgmt_irq_n_in, ext_mgmt_irq_n_out, ext_mgmt_irq_n_oe, smb_clk_oe, smb_data_oe;
	logic        lid_in, power_button_n, ring_wake_n, mgmt_bus_alert_n, bus_clk_halt_n;
	logic        sys_mgmt_irq_n, alert_irq, pm_resume, irq;
	logic [1:0]  htrans;
	logic [3:0]  bus_req_monitor_n;
	logic [31:0] haddr, hwdata, hrdata, expq[$];
	int          errors, tests_run, cyc;

	pm_event_input #(.DB_CYCLES(16)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.ext_mgmt_irq_n_in, .ext_mgmt_irq_n_out, .ext_mgmt_irq_n_oe, .serirq_smi_req, .lid_in,
		.power_button_n, .ring_wake_n, .mgmt_bus_alert_n, .bus_req_monitor_n, .bus_clk_halt_n,
		.smb_clk_out(), .smb_clk_oe, .smb_data_out(), .smb_data_oe, .sys_mgmt_irq_n,
		.alert_irq, .pm_resume, .irq);
	pm_event_sources src (.hclk, .oe(ext_mgmt_irq_n_oe), .ext_pin(ext_mgmt_irq_n_in),
		.lid(lid_in), .pwr_n(power_button_n), .ring_n(ring_wake_n), .alert_n(mgmt_bus_alert_n));

	// The bus clock never stops, even while the halt pin is low
	initial begin
		hclk = 0;
		forever #2.5 hclk = ~hclk;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk iff hreadyout);
		hsel   <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_dp  <= !w;
		@(posedge hclk iff hreadyout);
		rd_dp <= 0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(0, a, 32'h0);
	endtask

	task cy(input int n);
		repeat (n) @(posedge hclk);
	endtask

	task test_done();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Read data are compared against the oldest noted value when the transfer ends
	always @(posedge hclk) begin
		if (rd_dp && hreadyout)
			check(hrdata, expq.pop_front(), "hrdata");
		cyc++;
		if (cyc == 6000) begin
			errors++;
			test_done();
		end
	end

	initial begin
		logic [3:0] r;
		hresetn = 0;
		hsel = 0;
		haddr = 0;
		htrans = 0;
		hwrite = 0;
		hwdata = 0;
		rd_dp = 0;
		serirq_smi_req = 0;
		bus_req_monitor_n = 4'hf;
		errors = 0;
		tests_run = 0;
		cyc = 0;
		void'($urandom(94526));
		cy(20);
		hresetn <= 1;
		rd(8'h00, 32'h400);
		rd(8'h04, 0);
		rd(8'h08, 0);
		rd(8'h10, 0);
		check(bus_clk_halt_n, 1, "halt");
		bus(1, 8'h08, 32'h3f);
		bus(1, 8'h00, 32'h81f);
		src.drive(0, 0, 0);
		src.drive(0, 1, 10);
		check(sys_mgmt_irq_n, 0, "smi");
		check(irq, 1, "irq");
		rd(8'h04, 32'h1);
		bus(1, 8'h04, 32'h3f);
		serirq_smi_req <= 1;
		cy(2);
		check(ext_mgmt_irq_n_oe, 1, "oe");
		src.drive(0, 0, 0);
		src.drive(0, 1, 10);
		serirq_smi_req <= 0;
		cy(10);
		rd(8'h04, 0);
		src.drive(1, 0, 10);
		src.drive(1, 1, 30);
		rd(8'h04, 0);
		for (int i = 1; i < 4; i++) begin
			src.drive(i, 0, 30);
			check(sys_mgmt_irq_n, 32'(i != 1), "smi");
			check(pm_resume, 32'(i > 1), "res");
			rd(8'h04, 32'h1 << i);
			bus(1, 8'h04, 32'h3f);
			src.drive(i, 1, 30);
			rd(8'h04, 32'(i == 1) << 1);
			bus(1, 8'h04, 32'h3f);
		end
		for (int k = 0; k < 4; k++) begin
			bus(1, 8'h00, 32'h1f | (32'(k) << 11));
			src.drive(4, 0, 12);
			check(alert_irq, 32'(k == 0), "alert");
			check(sys_mgmt_irq_n, 32'(k != 1), "smi");
			check(pm_resume, 32'(k == 2), "res");
			check(irq, 1, "irq");
			src.drive(4, 1, 4);
			bus(1, 8'h04, 32'h3f);
		end
		bus(1, 8'h00, 32'hff);
		src.drive(1, 0, 30);
		src.drive(3, 0, 4);
		src.drive(4, 0, 8);
		rd(8'h0c, 32'h3f2);
		rd(8'h04, 0);
		src.drive(1, 1, 30);
		src.drive(3, 1, 4);
		src.drive(4, 1, 8);
		r = 4'($urandom_range(14, 0));
		bus_req_monitor_n <= r;
		cy(8);
		rd(8'h0c, {22'h0, 1'b1, r, 5'h1f});
		rd(8'h04, 32'h20);
		check(irq, 1, "irq");
		bus(1, 8'h08, 32'h1f);
		cy(2);
		check(irq, 0, "irq");
		bus_req_monitor_n <= 4'hf;
		cy(8);
		bus(1, 8'h04, 32'h3f);
		bus(1, 8'h00, 32'h200);
		cy(3);
		check(bus_clk_halt_n, 0, "halt");
		rd(8'h0c, 32'h1ff);
		bus(1, 8'h00, 32'h700);
		cy(3);
		check(bus_clk_halt_n, 1, "halt");
		bus(1, 8'h00, 32'h100);
		cy(3);
		check(bus_clk_halt_n, 0, "halt");
		bus_req_monitor_n <= 4'h0;
		cy(8);
		bus_req_monitor_n <= 4'hf;
		cy(8);
		rd(8'h04, 32'h20);
		hresetn <= 0;
		cy(2);
		hresetn <= 1;
		rd(8'h04, 0);
		rd(8'h00, 32'h400);
		check(bus_clk_halt_n, 1, "halt");
		test_done();
	end
endmodule // pm_event_input_tb_top
`default_nettype wire
